// file: hdl/hpsb_cfg.svh
// Constants for the host port sample buffer block
`ifndef HPSB_CFG_SVH
`define HPSB_CFG_SVH

// ==========================================================
// Host port addresses
`define HPSB_A_HOLD0 3'h0
`define HPSB_A_HOLD1 3'h1
`define HPSB_A_HOLD2 3'h2
`define HPSB_A_HOLD3 3'h3
`define HPSB_A_DEST 3'h4
`define HPSB_A_RSRC 3'h5
`define HPSB_A_STATUS 3'h7

// ==========================================================
// Destination control words
`define HPSB_CW_NCO 8'h00
`define HPSB_CW_GAIN 8'h08
`define HPSB_CW_ROUTE 8'h14
`define HPSB_CW_SNAP 8'h15
`define HPSB_CW_PRST 8'h16
`define HPSB_CW_RADV 8'h17

// ==========================================================
// Field positions
`define HPSB_NCO_SYNC_BIT 20
`define HPSB_GAIN_SYNC_BIT 29
`define HPSB_ROUTE_BIT 24
`define HPSB_SNAP_MODE_BIT 3
`define HPSB_THR_MSB 2
`define HPSB_THR_LSB 0
`define HPSB_IVL_MSB 11
`define HPSB_IVL_LSB 4
`define HPSB_CNT_MSB 3
`define HPSB_CNT_LSB 0

// ==========================================================
// Reset values and timing counts
`define HPSB_WR_PTR_RST 3'h0
`define HPSB_RD_PTR_RST 3'h7
`define HPSB_IRQ_LOW_CYC 4'h8
`define HPSB_DEST_DELAY 3'h4
`define HPSB_RSRC_RST 3'h0

`endif

// file: hdl/hpsb_pkg.sv
// Types shared by the host port sample buffer block
package hpsb_pkg;

  // One buffered sample set, stored at one address
  typedef struct packed {
    logic [15:0] i_val;
    logic [15:0] q_val;
    logic [15:0] mag_val;
    logic [15:0] phase_val;
    logic [15:0] freq_val;
  } hpsb_sample_type;

  // Assembled control word toward its destination
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
  } hpsb_cfg_type;

  typedef enum logic [1:0] {
    HPSB_DEST_IDLE = 2'b00,
    HPSB_DEST_WAIT = 2'b01,
    HPSB_DEST_ALIGN = 2'b10
  } hpsb_dest_state_type;

endpackage : hpsb_pkg

// file: hdl/hpsb_sync.sv
// Two flip-flop synchroniser for asynchronous pins
`timescale 1ns/100ps
module hpsb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule : hpsb_sync

// file: hdl/hpsb_mem.sv
// Sample buffer memory with registered read data
`timescale 1ns/100ps
module hpsb_mem #(
  parameter int W = 80,
  parameter int AW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // Read port, one cycle latency
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [W-1:0] rd_q;
  logic [W-1:0] rd_d;

  always_comb begin
    rd_d = mem[rd_addr];
  end

  // Array holds no reset; contents are don't-care until written
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
endmodule : hpsb_mem

// file: hdl/hpsb_host_port.sv
// Host port with indirect control writes and sample buffer
// Operation
// R1: Host clears route bit before buffer reads
// R2: Buffer interrupt low eight back-end cycles
// R3: Word 23 write advances read pointer
// R4: Host waits four back-end clocks after advance
// R5: Word 22 resets pointers to 0 and 7
// R6: Snapshot interval field plus one samples
// R7: Snapshot set count one to eight; full flag stops writes at six sets, so seven and eight never complete
// R8: Five values share one buffer address
// R9: Interval time-out restarts buffer filling
// R10: Host drains buffer before next time-out
// R11: Snapshot reads use FIFO read procedure
// R12: Addresses 0-3 load four holding bytes
// R13: Address 4 write loads destination later
// R14: Capture on rising edge of write strobe
// R15: Host waits four clocks between words
// R16: Load pulse aligned to target clock
// R17: Address 5 selects read data source
// R18: Second sync moves held gain value
// R19: First sync moves held centre frequency
// R20: Early reads need host depth tracking
// R21: Host masks interrupt while reading
// R22: Pointers never equal; full, empty blocking
// R23: Interrupt when depth reaches threshold
// R24: Interval counter counts sets and reloads
`timescale 1ns/100ps
`include "hpsb_cfg.svh"
module hpsb_host_port #(
  parameter logic [7:0] FE_WORD_LIMIT = 8'h08
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Rate enables from the clock divider
  input wire logic front_end_clock_en,
  input wire logic back_end_clock_en,
  // Host bus pins
  input wire logic host_wr_n,
  input wire logic host_rd_n,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  // Sync pins
  input wire logic sync_input_first,
  input wire logic sync_input_second,
  // Samples from the datapath
  input wire logic sample_valid,
  input wire hpsb_pkg::hpsb_sample_type sample_in,
  // Configuration load toward destinations
  output hpsb_pkg::hpsb_cfg_type cfg_wr,
  output logic cfg_load,
  output logic nco_transfer,
  output logic gain_transfer,
  // Interrupt
  output logic buffer_irq_n
);
  // ========================================================
  // Reset release and pin synchronisers
  logic rst_n_sync;
  logic wr_n_s;
  logic rd_n_s;
  logic [2:0] addr_s;
  logic [7:0] data_s;
  logic sync1_s;
  logic sync2_s;

  hpsb_sync #(.W(1), .RST_VAL(1'b0)) u_rst (
    .clk(clk), .rst_b(rst_b), .din(1'b1), .dout(rst_n_sync));
  hpsb_sync #(.W(2), .RST_VAL(2'b11)) u_strb (
    .clk(clk), .rst_b(rst_n_sync), .din({host_wr_n, host_rd_n}),
    .dout({wr_n_s, rd_n_s}));
  hpsb_sync #(.W(13), .RST_VAL(13'h0)) u_bus (
    .clk(clk), .rst_b(rst_n_sync),
    .din({host_addr, host_data_in, sync_input_first,
      sync_input_second}),
    .dout({addr_s, data_s, sync1_s, sync2_s}));

  // ========================================================
  // State
  logic wr_n_q, wr_n_d, rd_n_q, rd_n_d, sy1_q, sy1_d, sy2_q, sy2_d;
  logic [7:0] hold_q [0:3];
  logic [7:0] hold_d [0:3];
  logic [7:0] dest_q, dest_d;
  logic [2:0] rsrc_q, rsrc_d;
  hpsb_pkg::hpsb_dest_state_type dst_q, dst_d;
  logic [2:0] dcnt_q, dcnt_d;
  hpsb_pkg::hpsb_cfg_type cfg_q, cfg_d;
  logic load_q, load_d;
  logic route_q, route_d, snap_q, snap_d, nco_en_q, nco_en_d;
  logic gain_en_q, gain_en_d, ncox_q, ncox_d, gainx_q, gainx_d;
  logic [2:0] thr_q, thr_d, wp_q, wp_d, rp_q, rp_d;
  logic [7:0] ivl_q, ivl_d, ivc_q, ivc_d;
  logic [3:0] scnt_q, scnt_d, left_q, left_d, irq_q, irq_d;
  logic irqn_q, irqn_d;
  logic [7:0] dout_q, dout_d;
  logic wr_edge, rd_fall, mem_we, full, empty, trig;
  logic [2:0] mem_wa;
  logic [2:0] depth;
  logic [7:0] status, sel_byte;
  hpsb_pkg::hpsb_sample_type rdat;
  logic [3:0] nsets;

  hpsb_mem #(.W($bits(hpsb_pkg::hpsb_sample_type)), .AW(3)) u_mem (
    .clk(clk), .rst_b(rst_n_sync), .wr_en(mem_we), .wr_addr(mem_wa),
    .wr_data(sample_in), .rd_addr(rp_q), .rd_data(rdat)); // R8 R11

  // ========================================================
  // Buffer flags and read byte select
  always_comb begin
    depth = 3'(wp_q - rp_q - 3'h1); // R23
    full = (3'(wp_q + 3'h1) == rp_q); // R22
    empty = (3'(rp_q + 3'h1) == wp_q); // R22
    status = {depth, empty, full,
      ~(snap_q ? (left_q == 4'h0) : (depth >= thr_q)), 2'b00};
    sel_byte = 8'h00;
    case ({rsrc_q, addr_s})
      6'o00: sel_byte = rdat.i_val[7:0];
      6'o01: sel_byte = rdat.i_val[15:8];
      6'o02: sel_byte = rdat.q_val[7:0];
      6'o03: sel_byte = rdat.q_val[15:8];
      6'o10: sel_byte = rdat.mag_val[7:0];
      6'o11: sel_byte = rdat.mag_val[15:8];
      6'o12: sel_byte = rdat.phase_val[7:0];
      6'o13: sel_byte = rdat.phase_val[15:8];
      6'o20: sel_byte = rdat.freq_val[7:0];
      6'o21: sel_byte = rdat.freq_val[15:8];
      default: sel_byte = 8'h00;
    endcase
    // Buffer data reaches this bus only with the route bit clear
    if (route_q) begin
      sel_byte = 8'h00; // R1
    end
    if (addr_s == `HPSB_A_STATUS) begin
      sel_byte = status;
    end
  end

  // ========================================================
  // Next state
  always_comb begin
    wr_n_d = wr_n_s;
    rd_n_d = rd_n_s;
    sy1_d = sync1_s;
    sy2_d = sync2_s;
    wr_edge = !wr_n_q && wr_n_s; // R14
    rd_fall = rd_n_q && !rd_n_s;
    hold_d = hold_q;
    dest_d = dest_q;
    rsrc_d = rsrc_q;
    dst_d = dst_q;
    dcnt_d = dcnt_q;
    cfg_d = cfg_q;
    load_d = 1'b0;
    route_d = route_q;
    snap_d = snap_q;
    nco_en_d = nco_en_q;
    gain_en_d = gain_en_q;
    thr_d = thr_q;
    ivl_d = ivl_q;
    scnt_d = scnt_q;
    wp_d = wp_q;
    rp_d = rp_q;
    ivc_d = ivc_q;
    left_d = left_q;
    irq_d = irq_q;
    mem_we = 1'b0;
    mem_wa = wp_q;
    trig = 1'b0;
    nsets = (scnt_q == 4'h0) ? 4'h1 :
      (scnt_q > 4'h8) ? 4'h8 : scnt_q; // R7
    dout_d = rd_fall ? sel_byte : dout_q;
    if (wr_edge && addr_s <= `HPSB_A_HOLD3) begin
      hold_d[addr_s[1:0]] = data_s; // R12
    end
    if (wr_edge && addr_s == `HPSB_A_RSRC) begin
      rsrc_d = data_s[2:0]; // R17
    end
    case (dst_q)
      hpsb_pkg::HPSB_DEST_IDLE: begin
        if (wr_edge && addr_s == `HPSB_A_DEST) begin
          dest_d = data_s; // R13
          dst_d = hpsb_pkg::HPSB_DEST_WAIT;
          dcnt_d = 3'h1;
        end
      end
      hpsb_pkg::HPSB_DEST_WAIT: begin
        dcnt_d = 3'(dcnt_q + 3'h1);
        if (dcnt_q == `HPSB_DEST_DELAY - 3'h1) begin
          dst_d = hpsb_pkg::HPSB_DEST_ALIGN; // R13
        end
      end
      hpsb_pkg::HPSB_DEST_ALIGN: begin
        // Wait for an edge of the destination's own clock
        if (dest_q < FE_WORD_LIMIT ? front_end_clock_en
            : back_end_clock_en) begin // R16
          load_d = 1'b1;
          cfg_d.addr = dest_q;
          cfg_d.data = {hold_q[3], hold_q[2], hold_q[1], hold_q[0]};
          dst_d = hpsb_pkg::HPSB_DEST_IDLE;
        end
      end
      default: dst_d = hpsb_pkg::HPSB_DEST_IDLE;
    endcase
    // Words kept inside this block act on the load pulse
    if (load_q) begin
      case (cfg_q.addr)
        `HPSB_CW_NCO: nco_en_d = cfg_q.data[`HPSB_NCO_SYNC_BIT];
        `HPSB_CW_GAIN: gain_en_d = cfg_q.data[`HPSB_GAIN_SYNC_BIT];
        `HPSB_CW_ROUTE: begin
          route_d = cfg_q.data[`HPSB_ROUTE_BIT];
          snap_d = cfg_q.data[`HPSB_SNAP_MODE_BIT];
          thr_d = cfg_q.data[`HPSB_THR_MSB:`HPSB_THR_LSB];
        end
        `HPSB_CW_SNAP: begin
          ivl_d = cfg_q.data[`HPSB_IVL_MSB:`HPSB_IVL_LSB]; // R6
          scnt_d = cfg_q.data[`HPSB_CNT_MSB:`HPSB_CNT_LSB]; // R7
        end
        `HPSB_CW_RADV: begin
          if (!empty) begin
            rp_d = 3'(rp_q + 3'h1); // R3 R22
          end
        end
        default: begin
        end
      endcase
    end
    if (back_end_clock_en && sample_valid) begin
      if (snap_q) begin
        if (ivc_q == 8'h00) begin
          ivc_d = ivl_q; // R24 R6
          wp_d = 3'(`HPSB_WR_PTR_RST + 3'h1); // R9
          // First set of a snapshot always lands at the buffer start
          mem_wa = `HPSB_WR_PTR_RST; // R9
          rp_d = `HPSB_RD_PTR_RST;
          left_d = 4'(nsets - 4'h1);
          mem_we = 1'b1;
          trig = (nsets == 4'h1);
        end else begin
          ivc_d = 8'(ivc_q - 8'h01); // R24
          if (left_q != 4'h0 && !full) begin
            mem_we = 1'b1;
            wp_d = 3'(wp_q + 3'h1);
            left_d = 4'(left_q - 4'h1);
            trig = (left_q == 4'h1);
          end
        end
      end else if (!full) begin
        mem_we = 1'b1; // R22
        wp_d = 3'(wp_q + 3'h1);
        trig = (3'(depth + 3'h1) == thr_q); // R23
      end
    end
    if (load_q && cfg_q.addr == `HPSB_CW_PRST) begin
      wp_d = `HPSB_WR_PTR_RST; // R5
      rp_d = `HPSB_RD_PTR_RST;
      left_d = 4'h0;
      ivc_d = 8'h00;
      mem_we = 1'b0;
      trig = 1'b0;
    end
    if (trig) begin
      irq_d = `HPSB_IRQ_LOW_CYC; // R2
    end else if (back_end_clock_en && irq_q != 4'h0) begin
      irq_d = 4'(irq_q - 4'h1);
    end
    irqn_d = (irq_d == 4'h0);
    ncox_d = nco_en_q && sync1_s && !sy1_q; // R19
    gainx_d = gain_en_q && sync2_s && !sy2_q; // R18
  end

  // ========================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      sy1_q <= 1'b0;
      sy2_q <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        hold_q[k] <= 8'h00;
      end
      dest_q <= 8'h00;
      rsrc_q <= `HPSB_RSRC_RST;
      dst_q <= hpsb_pkg::HPSB_DEST_IDLE;
      dcnt_q <= 3'h0;
      cfg_q <= '0;
      load_q <= 1'b0;
      route_q <= 1'b0;
      snap_q <= 1'b0;
      nco_en_q <= 1'b0;
      gain_en_q <= 1'b0;
      thr_q <= 3'h0;
      ivl_q <= 8'h00;
      scnt_q <= 4'h0;
      wp_q <= `HPSB_WR_PTR_RST;
      rp_q <= `HPSB_RD_PTR_RST;
      ivc_q <= 8'h00;
      left_q <= 4'h0;
      irq_q <= 4'h0;
      irqn_q <= 1'b1;
      dout_q <= 8'h00;
      ncox_q <= 1'b0;
      gainx_q <= 1'b0;
    end else begin
      wr_n_q <= wr_n_d;
      rd_n_q <= rd_n_d;
      sy1_q <= sy1_d;
      sy2_q <= sy2_d;
      hold_q <= hold_d;
      dest_q <= dest_d;
      rsrc_q <= rsrc_d;
      dst_q <= dst_d;
      dcnt_q <= dcnt_d;
      cfg_q <= cfg_d;
      load_q <= load_d;
      route_q <= route_d;
      snap_q <= snap_d;
      nco_en_q <= nco_en_d;
      gain_en_q <= gain_en_d;
      thr_q <= thr_d;
      ivl_q <= ivl_d;
      scnt_q <= scnt_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      ivc_q <= ivc_d;
      left_q <= left_d;
      irq_q <= irq_d;
      irqn_q <= irqn_d;
      dout_q <= dout_d;
      ncox_q <= ncox_d;
      gainx_q <= gainx_d;
    end
  end

  assign host_data_out = dout_q;
  assign host_data_oe = !rd_n_s;
  assign cfg_wr = cfg_q;
  assign cfg_load = load_q;
  assign nco_transfer = ncox_q;
  assign gain_transfer = gainx_q;
  assign buffer_irq_n = irqn_q;

  // ========================================================
  // Checks
  logic [3:0] low_seen_q;
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      low_seen_q <= 4'h0;
    end else if (irqn_q) begin
      low_seen_q <= 4'h0;
    end else if (back_end_clock_en && low_seen_q != 4'hf) begin
      low_seen_q <= 4'(low_seen_q + 4'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_sync);

  sequence dest_taken;
    dst_q == hpsb_pkg::HPSB_DEST_IDLE && wr_edge
      && addr_s == `HPSB_A_DEST;
  endsequence
  sequence quiet_four;
    !load_q [*4];
  endsequence

  chk_irq_low_len: assert property ( // R2
    $rose(irqn_q) && !$past(trig) |-> low_seen_q == 4'h8)
    else $error("interrupt low time not eight back-end cycles");
  chk_ptr_reset: assert property ( // R5
    load_q && cfg_q.addr == `HPSB_CW_PRST |=> wp_q == 3'h0
      && rp_q == 3'h7)
    else $error("pointer reset values wrong");
  chk_read_adv: assert property ( // R3
    load_q && cfg_q.addr == `HPSB_CW_RADV && !empty && !snap_q
      |=> rp_q == 3'($past(rp_q) + 3'h1))
    else $error("read pointer did not advance");
  chk_ptrs_differ: assert property (wp_q != rp_q) // R22
    else $error("read and write pointers equal");
  chk_full_stall: assert property ( // R22
    full && !snap_q && !(load_q && cfg_q.addr == `HPSB_CW_PRST)
      |=> wp_q == $past(wp_q))
    else $error("write while buffer full");
  chk_dest_delay: assert property ( // R13
    dest_taken |=> quiet_four ##[0:300] load_q)
    else $error("destination load timing wrong");
  chk_hold_bytes: assert property ( // R12
    load_d |=> cfg_q.data == {$past(hold_q[3]), $past(hold_q[2]),
      $past(hold_q[1]), $past(hold_q[0])})
    else $error("assembled word differs from holding bytes");
  chk_load_align: assert property ( // R16
    load_q |-> $past(cfg_d.addr < FE_WORD_LIMIT ? front_end_clock_en
      : back_end_clock_en))
    else $error("load pulse not on target clock enable");
  chk_nco_xfer: assert property ( // R19
    $rose(sy1_q) && nco_en_q |-> ncox_q)
    else $error("centre frequency transfer missing");
endmodule : hpsb_host_port

// file: testbench/hpsb_host_model.sv
// Host processor model for the 8-bit host port
`timescale 1ns/100ps
module hpsb_host_model (
  // Clock
  input wire logic clk,
  // Host bus pins
  output logic wr_n,
  output logic rd_n,
  output logic [2:0] addr,
  output logic [7:0] data,
  input wire logic [7:0] rdata
);
  // ==========================================================
  // Bus cycles
  initial begin
    wr_n = 1'b1;
    rd_n = 1'b1;
    addr = 3'h0;
    data = 8'h00;
  end

  task automatic write_byte(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    data = d;
    wr_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    wr_n = 1'b1;
    // Pins are synced, so hold past the strobe edge
    repeat (4) @(posedge clk);
    #1;
    data = ~d;
  endtask : write_byte

  task automatic read_byte(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd_n = 1'b0;
    repeat (6) @(posedge clk);
    d = rdata;
    #1;
    rd_n = 1'b1;
    repeat (3) @(posedge clk);
  endtask : read_byte
endmodule : hpsb_host_model

// file: testbench/testbench.sv
// Self-checking bench for the host port sample buffer
`timescale 1ns/100ps
module testbench;
  logic clk;
  logic rst_b;
  logic [1:0] div = 2'd0;
  logic front_end_clock_en;
  logic back_end_clock_en;
  logic host_wr_n;
  logic host_rd_n;
  logic [2:0] host_addr;
  logic [7:0] host_data_in;
  logic [7:0] host_data_out;
  logic sync_input_first;
  logic sync_input_second;
  logic sample_valid;
  hpsb_pkg::hpsb_sample_type sample_in;
  hpsb_pkg::hpsb_cfg_type cfg_wr;
  hpsb_pkg::hpsb_cfg_type last_cfg;
  logic cfg_load;
  logic nco_transfer;
  logic gain_transfer;
  logic buffer_irq_n;
  logic irq_q;
  int errors;
  int cmp_count;
  int load_cnt;
  int nco_cnt;
  int gain_cnt;
  int irq_cnt;
  int low_en;

  // ==========================================================
  // Clock, rate enables, monitors
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    #1;
    div <= div + 2'd1;
  end
  assign front_end_clock_en = div[0];
  assign back_end_clock_en = (div == 2'd3);

  always @(posedge clk) begin
    if (cfg_load === 1'b1) begin
      load_cnt++;
      last_cfg = cfg_wr;
    end
    if (nco_transfer === 1'b1) nco_cnt++;
    if (gain_transfer === 1'b1) gain_cnt++;
    if (irq_q === 1'b1 && buffer_irq_n === 1'b0) irq_cnt++;
    if (buffer_irq_n === 1'b0 && back_end_clock_en === 1'b1) low_en++;
    irq_q = buffer_irq_n;
  end

  hpsb_host_port u_hpsb_host_port (
    .clk(clk), .rst_b(rst_b),
    .front_end_clock_en(front_end_clock_en),
    .back_end_clock_en(back_end_clock_en),
    .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
    .host_addr(host_addr), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(),
    .sync_input_first(sync_input_first),
    .sync_input_second(sync_input_second),
    .sample_valid(sample_valid), .sample_in(sample_in),
    .cfg_wr(cfg_wr), .cfg_load(cfg_load),
    .nco_transfer(nco_transfer), .gain_transfer(gain_transfer),
    .buffer_irq_n(buffer_irq_n)
  );

  hpsb_host_model u_hpsb_host_model (
    .clk(clk), .wr_n(host_wr_n), .rd_n(host_rd_n),
    .addr(host_addr), .data(host_data_in), .rdata(host_data_out)
  );

  // ==========================================================
  // Shared tasks
  task automatic report_and_stop;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [39:0] seen, input logic [39:0] exp,
                       input string msg);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : check

  function automatic logic [79:0] mk(input logic [7:0] n);
    return {8'h1A, n, 8'h2B, n, 8'h3C, n, 8'h4D, n, 8'h5E, n};
  endfunction : mk

  task automatic cfg_word(input logic [7:0] dest, input logic [31:0] d);
    int n0;
    int k;
    n0 = load_cnt;
    for (k = 0; k < 4; k++) begin
      u_hpsb_host_model.write_byte(k[2:0], d[8*k +: 8]);
    end
    u_hpsb_host_model.write_byte(3'h4, dest);
    k = 0;
    while (load_cnt == n0 && k < 60) begin
      @(posedge clk);
      #1;
      k++;
    end
    check(load_cnt - n0, 1, "control word load count");
    check(last_cfg, {dest, d}, "control word load");
    repeat (4) @(posedge clk);
  endtask : cfg_word

  task automatic feed(input logic [7:0] n);
    @(posedge clk);
    #1;
    sample_in = hpsb_pkg::hpsb_sample_type'(mk(n));
    sample_valid = 1'b1;
    do @(posedge clk); while (back_end_clock_en !== 1'b1);
    #1;
    sample_valid = 1'b0;
  endtask : feed

  task automatic advance;
    cfg_word(8'h17, 32'h0000_0000);
    repeat (20) @(posedge clk);
  endtask : advance

  task automatic rd_set(input logic [7:0] n, input string m);
    logic [7:0] d;
    logic [79:0] v;
    logic [31:0] w;
    int c;
    int a;
    v = mk(n);
    for (c = 0; c < 3; c++) begin
      u_hpsb_host_model.write_byte(3'h5, c[7:0]);
      w = (c == 0) ? {v[63:48], v[79:64]} :
          (c == 1) ? {v[31:16], v[47:32]} : {16'h0000, v[15:0]};
      for (a = 0; a < ((c == 2) ? 2 : 4); a++) begin
        u_hpsb_host_model.read_byte(a[2:0], d);
        check(d, w[8*a +: 8], m);
      end
    end
  endtask : rd_set

  task automatic sync_pulse(input bit sel, input int exp_n, input int exp_g);
    int n0;
    int g0;
    n0 = nco_cnt;
    g0 = gain_cnt;
    @(posedge clk);
    #1;
    if (sel) sync_input_second = 1'b1;
    else sync_input_first = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    sync_input_first = 1'b0;
    sync_input_second = 1'b0;
    repeat (8) @(posedge clk);
    check(nco_cnt - n0, exp_n, "centre frequency transfer");
    check(gain_cnt - g0, exp_g, "gain transfer");
  endtask : sync_pulse

  // ==========================================================
  // Scenarios
  task automatic test_cfg_sync;
    cfg_word(8'h00, 32'h0018_D038);
    cfg_word(8'h09, 32'hA5C3_5A3C);
    sync_pulse(1'b0, 1, 0);
    cfg_word(8'h08, 32'h2000_0000);
    sync_pulse(1'b1, 0, 1);
    cfg_word(8'h08, 32'h0000_0000);
    sync_pulse(1'b1, 0, 0);
  endtask : test_cfg_sync

  task automatic test_fifo;
    logic [7:0] st;
    int i0;
    int k;
    int l0;
    cfg_word(8'h14, 32'h0000_0003);
    cfg_word(8'h16, 32'h0000_0000);
    l0 = low_en;
    i0 = irq_cnt;
    feed(8'h00);
    feed(8'h01);
    repeat (8) @(posedge clk);
    check(irq_cnt - i0, 0, "interrupt below threshold");
    feed(8'h02);
    repeat (40) @(posedge clk);
    check(irq_cnt - i0, 1, "interrupt at threshold");
    check(low_en - l0, 8, "interrupt width");
    u_hpsb_host_model.read_byte(3'h7, st);
    check(st[7:3], 5'b01100, "status depth three");
    for (k = 3; k < 8; k++) feed(k[7:0]);
    u_hpsb_host_model.read_byte(3'h7, st);
    check(st[7:3], 5'b11001, "status full");
    for (k = 0; k < 6; k++) begin
      advance();
      rd_set(k[7:0], "fifo sample set");
    end
    u_hpsb_host_model.read_byte(3'h7, st);
    check(st[7:3], 5'b00010, "status empty");
    // Advance on an empty buffer must leave the last set in view
    advance();
    rd_set(8'h05, "blocked advance");
    cfg_word(8'h14, 32'h0100_0003);
    u_hpsb_host_model.write_byte(3'h5, 8'h00);
    u_hpsb_host_model.read_byte(3'h0, st);
    check(st, 8'h00, "buffer routed away");
  endtask : test_fifo

  task automatic test_snap;
    logic [7:0] a;
    logic [7:0] b;
    int i0;
    int k;
    cfg_word(8'h14, 32'h0000_0008);
    cfg_word(8'h15, 32'h0000_0032);
    cfg_word(8'h16, 32'h0000_0000);
    i0 = irq_cnt;
    k = 0;
    // Stop feeding at the interrupt so no time-out overwrites
    while (irq_cnt == i0 && k < 12) begin
      feed(8'h20 + k[7:0]);
      repeat (3) @(posedge clk);
      k++;
    end
    check(irq_cnt - i0, 1, "snapshot complete");
    advance();
    u_hpsb_host_model.write_byte(3'h5, 8'h00);
    u_hpsb_host_model.read_byte(3'h0, a);
    advance();
    u_hpsb_host_model.read_byte(3'h0, b);
    check(b, a + 8'h01, "adjacent snapshot sets");
    // Samples three to six: the fifth starts a new snapshot at slot 0
    i0 = irq_cnt;
    for (k = 2; k < 6; k++) begin
      feed(8'h20 + k[7:0]);
      repeat (3) @(posedge clk);
    end
    check(irq_cnt - i0, 1, "second snapshot complete");
    advance();
    u_hpsb_host_model.read_byte(3'h0, a);
    check(a, 8'h24, "time-out rewrites from start");
  endtask : test_snap

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst_b = 1'b0;
    sync_input_first = 1'b0;
    sync_input_second = 1'b0;
    sample_valid = 1'b0;
    sample_in = '0;
    repeat (6) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (8) @(posedge clk);
    test_cfg_sync();
    test_fifo();
    test_snap();
    report_and_stop();
  end

  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule : testbench
